// ==== design/irc_defs.vh ====
// constants for the interrupt and reset-state controller
// assumes a 20 MHz clk_sys and the plain strobe register port
`ifndef IRC_DEFS_VH
`define IRC_DEFS_VH
// ****************************************
// register offsets
// ****************************************
`define IRC_ADDR_W        4
`define IRC_OFF_CONTROL   4'h0
`define IRC_OFF_PFLAG     4'h1
`define IRC_OFF_PMASK     4'h2
`define IRC_OFF_STATUS    4'h3
`define IRC_OFF_PSTAT     4'h4
`define IRC_OFF_OPTION    4'h5
`define IRC_OFF_CORE      4'h6
`define IRC_OFF_PC_LO     4'h7
`define IRC_OFF_PC_HI     4'h8
// ****************************************
// control, option, status and power status register fields
// ****************************************
`define IRC_B_GIE         7
`define IRC_B_PERIPH_GROUP_ENABLE        6
`define IRC_B_TIE         5
`define IRC_B_EIE         4
`define IRC_B_PCIE        3
`define IRC_B_TIF         2
`define IRC_B_EIF         1
`define IRC_B_PCIF        0
`define IRC_B_EDGE        6
`define IRC_B_PD          3
`define IRC_B_TO          4
`define IRC_B_BROWN       0
`define IRC_B_PWRON       1
// core register: bit0 sleep status, writes: bit0 enter sleep, bit1 return
`define IRC_B_SLEEP       0
`define IRC_B_RETURN      1
// ****************************************
// reset values and vectors
// ****************************************
`define IRC_PC_W          13
`define IRC_PC_RESET      13'h0000
`define IRC_PC_VECTOR     13'h0004
`define IRC_OPTION_RESET  8'hFF
`define IRC_STATUS_POR    8'h18
`define IRC_PSTAT_POR     8'h00
// ****************************************
// reset causes
// ****************************************
`define IRC_RC_NONE       3'h0
`define IRC_RC_POR        3'h1
`define IRC_RC_BOR        3'h2
`define IRC_RC_PIN        3'h3
`define IRC_RC_WDOG       3'h4
`endif

// ==== design/irc_sync.v ====
// three-flop synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clk_sys
`timescale 1ns/10ps
module irc_sync
(
   input  wire clk_sys,
   input  wire sys_rst,
   input  wire pin_in,
   output reg  level_reg
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   // change counts only once flops two and three agree
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         s1_reg    <= 1'b0;
         s2_reg    <= 1'b0;
         s3_reg    <= 1'b0;
         level_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
            level_reg <= s3_reg;
      end
   end
endmodule // irc_sync

// ==== design/irc_ctrl.v ====
// interrupt controller with reset and wake-up state of pc, status and power flags
// assumes a core that takes vec_pc on vec_take and reports instruction boundaries
// Function
// - nine sources, each with own flag
// - flags set regardless of any enable
// - bit 7 global enable gates vectoring
// - every reset clears global enable
// - taken interrupt clears enable, vectors 0004h
// - return pops address, sets global enable
// - peripheral flags, masks, group enable
// - external event latency three to four cycles
// - edge pin polarity from option bit 6
// - edge enable bit 4, wakes sleep
// - tick wrap sets bit 2, enable 5
// - port high nibble change sets bit 0
// - interrupt wake vectors only if enabled
// - power-on and brown-out status values
// - pin reset keeps timeout, powerdown, power flags
// - pin reset in sleep sets timeout
// - watchdog reset and wake status values
// - interrupt wake sets timeout, clears powerdown
// - control register reset values, kept on wake
// - wake touches only causing flags
// - power status bits brown-out 0, on 1
// - powerdown bit 3, timeout bit 4
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "irc_defs.vh"
module irc_ctrl
#(
   parameter NPER = 6
)
(
   input  wire                   clk_sys,
   input  wire                   sys_rst,
   input  wire [2:0]             reset_cause,
   input  wire                   in_sleep_at_reset,
   input  wire                   ext_irq_pin,
   input  wire [3:0]             upper_port,
   input  wire                   tick_wrap,
   input  wire [NPER-1:0]        periph_event,
   input  wire                   watchdog_timeout,
   input  wire                   instr_boundary,
   input  wire [`IRC_PC_W-1:0]   next_pc,
   input  wire [`IRC_ADDR_W-1:0] reg_addr,
   input  wire [7:0]             reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [7:0]             reg_rdata,
   output reg                    vec_take,
   output reg  [`IRC_PC_W-1:0]   vec_pc,
   output reg                    sleep_reg,
   output reg                    core_reset,
   output reg                    irq_pending
);
   // ****************************************
   // state
   // ****************************************
   reg  [7:0]           ctrl_reg;
   reg  [7:0]           ctrl_next;
   reg  [NPER-1:0]      pflag_reg;
   reg  [NPER-1:0]      pflag_next;
   reg  [NPER-1:0]      pmask_reg;
   reg  [7:0]           status_reg;
   reg  [1:0]           pstat_reg;
   reg  [7:0]           option_reg;
   reg  [`IRC_PC_W-1:0] ret_pc_reg;
   reg                  ext_prev_reg;
   reg  [3:0]           port_prev_reg;
   reg                  req_wait_reg;
   reg                  req_due_reg;
   wire                 ext_lvl;
   wire [3:0]           port_lvl;
   wire                 ext_edge;
   wire                 port_chg;
   wire                 any_req;
   wire                 wr_ctrl;
   wire                 wr_pflag;
   wire                 rst_any;
   // ****************************************
   // pin synchronisers
   // ****************************************
   irc_sync u_ext_sync
   (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .pin_in    (ext_irq_pin),
      .level_reg (ext_lvl)
   );
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_port
         irc_sync u_port_sync
         (
            .clk_sys   (clk_sys),
            .sys_rst   (sys_rst),
            .pin_in    (upper_port[gi]),
            .level_reg (port_lvl[gi])
         );
      end
   endgenerate
   // ****************************************
   // event detection and request
   // ****************************************
   assign ext_edge = option_reg[`IRC_B_EDGE] ? (ext_lvl & ~ext_prev_reg)
                                             : (~ext_lvl & ext_prev_reg);
   assign port_chg = |(port_lvl ^ port_prev_reg);
   assign wr_ctrl  = reg_wr && (reg_addr == `IRC_OFF_CONTROL);
   assign wr_pflag = reg_wr && (reg_addr == `IRC_OFF_PFLAG);
   assign rst_any  = (reset_cause != `IRC_RC_NONE);
   assign any_req  = (ctrl_reg[`IRC_B_TIF]  & ctrl_reg[`IRC_B_TIE])
                   | (ctrl_reg[`IRC_B_EIF]  & ctrl_reg[`IRC_B_EIE])
                   | (ctrl_reg[`IRC_B_PCIF] & ctrl_reg[`IRC_B_PCIE])
                   | (ctrl_reg[`IRC_B_PERIPH_GROUP_ENABLE] & |(pflag_reg & pmask_reg));
   // flags: software value first, then hardware sets on top
   always @*
   begin
      ctrl_next  = wr_ctrl  ? reg_wdata : ctrl_reg;
      pflag_next = wr_pflag ? reg_wdata[NPER-1:0] : pflag_reg;
      if (tick_wrap)
         ctrl_next[`IRC_B_TIF] = 1'b1;
      if (ext_edge)
         ctrl_next[`IRC_B_EIF] = 1'b1;
      if (port_chg)
         ctrl_next[`IRC_B_PCIF] = 1'b1;
      pflag_next = pflag_next | periph_event;
   end
   // ****************************************
   // main sequencing
   // ****************************************
   always @(posedge clk_sys)
   begin
      if (sys_rst)
      begin
         ctrl_reg      <= 8'h00;
         pflag_reg     <= {NPER{1'b0}};
         pmask_reg     <= {NPER{1'b0}};
         status_reg    <= `IRC_STATUS_POR;
         pstat_reg     <= 2'h0;
         option_reg    <= `IRC_OPTION_RESET;
         ret_pc_reg    <= `IRC_PC_RESET;
         ext_prev_reg  <= 1'b0;
         port_prev_reg <= 4'h0;
         req_wait_reg  <= 1'b0;
         req_due_reg   <= 1'b0;
         vec_take      <= 1'b0;
         vec_pc        <= `IRC_PC_RESET;
         sleep_reg     <= 1'b0;
         core_reset    <= 1'b1;
         irq_pending   <= 1'b0;
      end
      else if (rst_any)
      begin
         // flag bit 0 survives pin and watchdog; kept on power resets too
         ctrl_reg     <= {7'h00, ctrl_reg[`IRC_B_PCIF]};
         pflag_reg    <= {NPER{1'b0}};
         pmask_reg    <= {NPER{1'b0}};
         option_reg   <= `IRC_OPTION_RESET;
         vec_pc       <= `IRC_PC_RESET;
         vec_take     <= 1'b0;
         sleep_reg    <= 1'b0;
         core_reset   <= 1'b1;
         req_wait_reg <= 1'b0;
         req_due_reg  <= 1'b0;
         irq_pending  <= 1'b0;
         case (reset_cause)
            `IRC_RC_POR:
            begin
               status_reg <= `IRC_STATUS_POR;
               pstat_reg[`IRC_B_PWRON] <= 1'b0;
            end
            `IRC_RC_BOR:
            begin
               status_reg <= `IRC_STATUS_POR;
               pstat_reg[`IRC_B_BROWN] <= 1'b0;
            end
            `IRC_RC_PIN:
            begin
               status_reg[7:5] <= 3'h0;
               if (in_sleep_at_reset)
               begin
                  status_reg[`IRC_B_TO] <= 1'b1;
                  status_reg[`IRC_B_PD] <= 1'b0;
               end
            end
            `IRC_RC_WDOG:
            begin
               status_reg[7:5]       <= 3'h0;
               status_reg[`IRC_B_TO] <= 1'b0;
               status_reg[`IRC_B_PD] <= 1'b1;
            end
            default:
               status_reg <= status_reg;
         endcase
      end
      else
      begin
         core_reset    <= 1'b0;
         ext_prev_reg  <= ext_lvl;
         port_prev_reg <= port_lvl;
         ctrl_reg      <= ctrl_next;
         pflag_reg     <= pflag_next;
         vec_take      <= 1'b0;
         irq_pending   <= any_req;
         if (reg_wr && reg_addr == `IRC_OFF_PMASK)
            pmask_reg <= reg_wdata[NPER-1:0];
         if (reg_wr && reg_addr == `IRC_OFF_OPTION)
            option_reg <= reg_wdata;
         if (reg_wr && reg_addr == `IRC_OFF_STATUS)
            status_reg[7:5] <= reg_wdata[7:5];
         if (reg_wr && reg_addr == `IRC_OFF_PSTAT)
            pstat_reg <= reg_wdata[1:0];
         if (reg_wr && reg_addr == `IRC_OFF_CORE && reg_wdata[`IRC_B_RETURN])
         begin
            ctrl_reg[`IRC_B_GIE] <= 1'b1;
            vec_pc   <= ret_pc_reg;
            vec_take <= 1'b1;
         end
         if (sleep_reg)
         begin
            // wake: status bits only; flags were set by the event itself
            if (watchdog_timeout)
            begin
               sleep_reg             <= 1'b0;
               status_reg[`IRC_B_TO] <= 1'b0;
               status_reg[`IRC_B_PD] <= 1'b0;
               vec_pc                <= next_pc;
               vec_take              <= 1'b1;
            end
            else if (any_req)
            begin
               sleep_reg             <= 1'b0;
               status_reg[`IRC_B_TO] <= 1'b1;
               status_reg[`IRC_B_PD] <= 1'b0;
               vec_pc                <= next_pc;
               vec_take              <= 1'b1;
               req_wait_reg          <= ctrl_reg[`IRC_B_GIE];
            end
         end
         else if (reg_wr && reg_addr == `IRC_OFF_CORE && reg_wdata[`IRC_B_SLEEP])
         begin
            // a pending enabled request turns sleep into a no-op
            if (!any_req)
            begin
               sleep_reg             <= 1'b1;
               status_reg[`IRC_B_TO] <= 1'b1;
               status_reg[`IRC_B_PD] <= 1'b0;
            end
         end
         else if (ctrl_reg[`IRC_B_GIE] && any_req && !req_wait_reg)
            req_wait_reg <= 1'b1;
         // two cycles of staging plus the boundary gives three to four cycles
         if (req_wait_reg && !sleep_reg)
            req_due_reg <= 1'b1;
         if (req_due_reg && instr_boundary && ctrl_reg[`IRC_B_GIE])
         begin
            ctrl_reg[`IRC_B_GIE] <= 1'b0;
            ret_pc_reg   <= next_pc;
            vec_pc       <= `IRC_PC_VECTOR;
            vec_take     <= 1'b1;
            req_wait_reg <= 1'b0;
            req_due_reg  <= 1'b0;
         end
         else if (!ctrl_reg[`IRC_B_GIE] && !sleep_reg)
         begin
            req_wait_reg <= 1'b0;
            req_due_reg  <= 1'b0;
         end
      end
   end
   // ****************************************
   // register read
   // ****************************************
   always @(posedge clk_sys)
   begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            `IRC_OFF_CONTROL: reg_rdata <= ctrl_reg;
            `IRC_OFF_PFLAG:   reg_rdata <= {{(8-NPER){1'b0}}, pflag_reg};
            `IRC_OFF_PMASK:   reg_rdata <= {{(8-NPER){1'b0}}, pmask_reg};
            `IRC_OFF_STATUS:  reg_rdata <= status_reg;
            `IRC_OFF_PSTAT:   reg_rdata <= {6'h00, pstat_reg};
            `IRC_OFF_OPTION:  reg_rdata <= option_reg;
            `IRC_OFF_CORE:    reg_rdata <= {7'h00, sleep_reg};
            `IRC_OFF_PC_LO:   reg_rdata <= ret_pc_reg[7:0];
            `IRC_OFF_PC_HI:   reg_rdata <= {3'h0, ret_pc_reg[12:8]};
            default:          reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end
endmodule // irc_ctrl

// ==== tb/irc_sva.sv ====
// checker for the port timing of irc_ctrl
// assumes it is bound onto irc_ctrl, one clock domain
`timescale 1ns/10ps
module irc_sva
(
   input wire        clk_sys,
   input wire        sys_rst,
   input wire [2:0]  reset_cause,
   input wire [3:0]  reg_addr,
   input wire        reg_rd,
   input wire [7:0]  reg_rdata,
   input wire        vec_take,
   input wire [12:0] vec_pc,
   input wire        sleep_reg,
   input wire        core_reset,
   input wire        irq_pending
);
   default clocking cb @(posedge clk_sys); endclocking
   // ******
   // reset behaviour, not disabled by reset
   // ******
   chk_rst_core: assert property (sys_rst |=> core_reset)
      else $error("core not held in reset");
   chk_rst_quiet: assert property (sys_rst |=> !vec_take && !sleep_reg)
      else $error("vector or sleep after reset");
   chk_rst_pend: assert property (sys_rst |=> (!irq_pending) [*2])
      else $error("request pending after reset");
   chk_rst_release: assert property ($fell(sys_rst) && reset_cause == 3'h0 |=> !core_reset)
      else $error("core reset not released");
   // ******
   // run time
   // ******
   chk_cause_core: assert property (disable iff (sys_rst) reset_cause != 3'h0 |=> core_reset)
      else $error("reset cause did not reset core");
   chk_rd_idle: assert property (disable iff (sys_rst) !$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   chk_sleep_rd: assert property (disable iff (sys_rst)
      $past(reg_rd) && $past(reg_addr) == 4'h6 |-> reg_rdata[0] == $past(sleep_reg))
      else $error("sleep status read wrong");
   // a change of vec_pc with no vector would send the core astray
   chk_vec_hold: assert property (disable iff (sys_rst)
      !vec_take && !$past(sys_rst) && !$past(core_reset) && $past(reset_cause) == 3'h0 |-> $stable(vec_pc))
      else $error("vector address moved");
endmodule // irc_sva
bind irc_ctrl irc_sva i_sva
(
   .clk_sys(clk_sys), .sys_rst(sys_rst), .reset_cause(reset_cause), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vec_take(vec_take), .vec_pc(vec_pc),
   .sleep_reg(sleep_reg), .core_reset(core_reset), .irq_pending(irq_pending)
);

// ==== tb/irc_core_model.sv ====
// stand-in for the processor core beside irc_ctrl
// assumes irc_ctrl outputs on the same clock
`timescale 1ns/10ps
module irc_core_model
(
   input  wire        clk_sys,
   input  wire        core_reset,
   input  wire        vec_take,
   input  wire [12:0] vec_pc,
   input  wire        sleep_reg,
   input  wire        slow,
   output reg         instr_boundary,
   output wire [12:0] next_pc
);
   reg [12:0] pc_reg;
   // pc moves only on vectors so return addresses are predictable
   assign next_pc = pc_reg + 13'h0001;
   always @(posedge clk_sys)
   begin
      if (core_reset)
      begin
         pc_reg         <= 13'h0000;
         instr_boundary <= 1'b0;
      end
      else
      begin
         instr_boundary <= !sleep_reg && (slow ? !instr_boundary : 1'b1);
         if (vec_take)
            pc_reg <= vec_pc;
      end
   end
endmodule // irc_core_model

// ==== tb/tb.sv ====
// testbench for irc_ctrl: register tasks and scenarios
// assumes the core model and the bound checker
`timescale 1ns/10ps
module tb;
   reg         clk_sys, sys_rst, in_sleep_at_reset, ext_irq_pin, tick_wrap;
   reg         watchdog_timeout, reg_wr, reg_rd, slow;
   reg  [2:0]  reset_cause;
   reg  [3:0]  upper_port, reg_addr;
   reg  [5:0]  periph_event;
   reg  [7:0]  reg_wdata;
   wire [7:0]  reg_rdata;
   wire [12:0] next_pc, vec_pc;
   wire        instr_boundary, vec_take, sleep_reg, core_reset, irq_pending;
   integer     fail_count, comparisons, i;
   integer     vec_count = 0, vec_done = 0;
   reg  [31:0] e;
   // vec_take stands one cycle, often inside a write task, so pulses are counted
   always @(posedge clk_sys)
      if (vec_take === 1'b1)
         vec_count <= vec_count + 1;
   // cause, sleep, status, power status, power status mask
   localparam [159:0] RC = {32'h201802FF, 32'h400803FF, 32'h300803FF, 32'h311003FF, 32'h10180002};
   irc_ctrl #(.NPER(6)) i_dut
   (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .reset_cause(reset_cause), .in_sleep_at_reset(in_sleep_at_reset),
      .ext_irq_pin(ext_irq_pin), .upper_port(upper_port), .tick_wrap(tick_wrap), .periph_event(periph_event),
      .watchdog_timeout(watchdog_timeout), .instr_boundary(instr_boundary), .next_pc(next_pc),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .vec_take(vec_take), .vec_pc(vec_pc), .sleep_reg(sleep_reg), .core_reset(core_reset),
      .irq_pending(irq_pending)
   );
   irc_core_model i_core
   (
      .clk_sys(clk_sys), .core_reset(core_reset), .vec_take(vec_take), .vec_pc(vec_pc),
      .sleep_reg(sleep_reg), .slow(slow), .instr_boundary(instr_boundary), .next_pc(next_pc)
   );
   // ******
   // tasks
   // ******
   task chk(input [15:0] g, input [15:0] x);
      comparisons = comparisons + 1;
      if (g !== x)
      begin
         fail_count = fail_count + 1;
         $display("ERROR %0t got %h exp %h", $time, g, x);
      end
   endtask
   task results;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // one-cycle event strobes ride along with a write and drop with it
   task wr(input [3:0] a, input [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      periph_event <= 6'h00;
      tick_wrap <= 1'b0;
      watchdog_timeout <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask
   task rc(input [3:0] a, input [7:0] x, input [7:0] m);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata & m, x);
      @(posedge clk_sys);
      #1;
   endtask
   task wt(input [1:0] s);
      integer n;
      n = 0;
      while (s == 0 ? vec_count == vec_done : s == 1 ? sleep_reg !== 1'b0 : core_reset !== 1'b0)
      begin
         @(posedge clk_sys);
         #1;
         n = n + 1;
         if (n == 40)
         begin
            chk(16'h0001, 16'h0000);
            results;
         end
      end
      if (s == 0)
         vec_done = vec_count;
   endtask
   task pe(input [4:0] v, input [7:0] x);
      {upper_port, ext_irq_pin} <= v;
      repeat (10) @(posedge clk_sys);
      #1;
      rc(4'h0, x, 8'hFF);
      wr(4'h0, 8'h00);
   endtask
   // ******
   // scenarios
   // ******
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial
   begin
      {sys_rst, reset_cause, in_sleep_at_reset, ext_irq_pin, upper_port, tick_wrap} = 11'h400;
      {periph_event, watchdog_timeout, reg_addr, reg_wdata, reg_wr, reg_rd, slow} = 0;
      fail_count = 0;
      comparisons = 0;
      repeat (8) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      for (i = 0; i < 7; i++)
         rc(i[3:0], 56'h0000001800FF00 >> (48 - 8 * i), i == 0 ? 8'hFE : 8'hFF);
      tick_wrap <= 1'b1;
      wr(4'hF, 8'h55);
      rc(4'hF, 8'h00, 8'hFF);
      rc(4'h0, 8'h04, 8'hFF);
      chk(irq_pending, 16'h0000);
      wr(4'h0, 8'h24);
      chk(irq_pending, 16'h0001);
      wr(4'h0, 8'hA4);
      wt(0);
      chk(vec_pc, 13'h0004);
      rc(4'h0, 8'h24, 8'hFF);
      rc(4'h7, 8'h01, 8'hFF);
      rc(4'h8, 8'h00, 8'hFF);
      wr(4'h0, 8'h20);
      wr(4'h6, 8'h02);
      wt(0);
      chk(vec_pc, 13'h0001);
      rc(4'h0, 8'hA0, 8'hFF);
      wr(4'h0, 8'h00);
      pe(5'h01, 8'h02);
      wr(4'h5, 8'hBF);
      pe(5'h00, 8'h02);
      pe(5'h01, 8'h00);
      slow <= 1'b1;
      wr(4'h0, 8'h90);
      ext_irq_pin <= 1'b0;
      wt(0);
      chk(vec_pc, 13'h0004);
      wr(4'h0, 8'h00);
      pe(5'h0A, 8'h01);
      wr(4'h2, 8'h01);
      periph_event <= 6'h01;
      wr(4'h1, 8'h00);
      rc(4'h1, 8'h01, 8'hFF);
      chk(irq_pending, 16'h0000);
      wr(4'h0, 8'h40);
      chk(irq_pending, 16'h0001);
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h08);
      wr(4'h3, 8'hA0);
      wr(4'h6, 8'h01);
      rc(4'h3, 8'hB0, 8'hF8);
      upper_port <= 4'h0;
      wt(1);
      chk(vec_pc, 13'h0005);
      rc(4'h3, 8'hB0, 8'hF8);
      rc(4'h0, 8'h09, 8'hFF);
      wr(4'h0, 8'h00);
      wr(4'h6, 8'h01);
      watchdog_timeout <= 1'b1;
      wr(4'hF, 8'h00);
      wt(1);
      chk(vec_pc, 13'h0006);
      rc(4'h3, 8'hA0, 8'hF8);
      // wake with global enable: continue at next address, then vector
      vec_done = vec_count;
      wr(4'h0, 8'h88);
      wr(4'h6, 8'h01);
      upper_port <= 4'h5;
      wt(1);
      wt(0);
      chk(vec_pc, 13'h0007);
      wt(0);
      chk(vec_pc, 13'h0004);
      for (i = 0; i < 5; i++)
      begin
         e = RC[159 - 32 * i -: 32];
         wr(4'h3, 8'hE0);
         wr(4'h4, 8'h03);
         wr(4'h0, 8'h80);
         reset_cause <= e[30:28];
         in_sleep_at_reset <= e[24];
         repeat (2) @(posedge clk_sys);
         reset_cause <= 3'h0;
         #1;
         wt(2);
         chk(vec_pc, 13'h0000);
         rc(4'h3, e[23:16], 8'hF8);
         rc(4'h4, e[15:8], e[7:0]);
         rc(4'h0, 8'h00, 8'hFE);
      end
      results;
   end
endmodule // tb
